// file: hw/ric_pkg.sv
// Package for the restart interlock control block: register map,
// field positions, reset values and timing constants.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package ric_pkg;

   // Clock rate, switch hold limits, offline, hour and debounce timing
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned HOLD_MIN_MS    = 500;
   localparam int unsigned HOLD_MAX_MS    = 4500;
   localparam int unsigned OFFLINE_S      = 40;
   localparam int unsigned HOUR_S         = 3600;
   localparam int unsigned MS_CYC         = CLK_HZ / 1000;
   localparam int unsigned HOLD_MIN_CYC   = HOLD_MIN_MS * MS_CYC;
   localparam int unsigned HOLD_MAX_CYC   = HOLD_MAX_MS * MS_CYC;
   localparam int unsigned OFFLINE_MS     = OFFLINE_S * 1000;
   localparam int unsigned HOUR_MS        = HOUR_S * 1000;
   localparam int unsigned DEBOUNCE_CYC   = 16;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL        = 8'h00;
   localparam logic [7:0] REG_STATUS      = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT    = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK    = 8'h0C;
   localparam logic [7:0] REG_IP_ADDR     = 8'h10;
   localparam logic [7:0] REG_CHAIN       = 8'h14;
   localparam logic [7:0] REG_HOURS       = 8'h18;
   localparam logic [7:0] REG_MENU        = 8'h1C;

   // CTRL fields
   localparam int CTRL_STOP      = 0;
   localparam int CTRL_FAULT     = 1;
   localparam int CTRL_OBJ       = 2;
   localparam int CTRL_FACTORY   = 3;
   localparam int CTRL_ROTATE    = 4;
   localparam int CTRL_SEL_LO    = 8;
   localparam int CTRL_TEST_DONE = 12;

   // Interrupt event bits
   localparam int EV_ACCEPT   = 0;
   localparam int EV_DISCARD  = 1;
   localparam int EV_READY    = 2;
   localparam int EV_LOCKOUT  = 3;
   localparam int EV_FACTORY  = 4;
   localparam int EV_W        = 5;

   // Reset values
   localparam logic [31:0] IP_DEFAULT = 32'hC0A8_000A;
   localparam logic [1:0]  CHAIN_DEF  = 2'h0;

   // Menu buttons and entries
   localparam int BTN_SQUARE = 0;
   localparam int BTN_UP     = 1;
   localparam int BTN_DOWN   = 2;

   typedef enum logic [1:0] {
      RIC_MENU_INFO  = 2'b00,
      RIC_MENU_SET   = 2'b01,
      RIC_MENU_EXIT  = 2'b11
   } ric_menu_t;

   // Device run state, Gray along startup -> interlock -> run
   typedef enum logic [2:0] {
      RIC_ST_STARTUP   = 3'b000,
      RIC_ST_INTERLOCK = 3'b001,
      RIC_ST_RUN       = 3'b011,
      RIC_ST_LOCKOUT   = 3'b010,
      RIC_ST_WAITCFG   = 3'b110
   } ric_state_t;

endpackage

// file: hw/ric_top.sv
// Restart interlock control: switch qualification, interlock and lockout
// state, startup test timing, address reservation, menu and run hours.
// Assumes an APB master on pclk and raw pins needing synchronisation.
//
// Overview of operation
// - Request accepted if switch closed 0.5 to 4.5 s, acts on opening
// - Switch held past 4.5 s discards that request entirely
// - After stop, stay in interlock with outputs off until restart
// - Lockout holds until fault cleared and valid reset arrives
// - Reset reruns startup tests, offline about 40 seconds
// - Restart accepted only once object has left protected zone
// - Restart pending lights indicator amber and restart symbol
// - Any multi-function pin selectable as reset/restart input
// - Use configured address, default 192.168.0.10, plus next one
// - Each cascade remote takes next two consecutive addresses
// - Factory reset restores password, access, address, config; code holds no password or access state
// - After factory restore, every scanner restarts awaiting config
// - Square opens menu, up/down walk info, settings, exit
// - Display setting rotates image by 180 degrees
// - Settings reset entry restarts like a power cycle
// - Lifetime run hours counter readable in hardware info
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ric_top
   import ric_pkg::*;
#(
   parameter int unsigned N_PINS      = 4,
   parameter int unsigned OFFLINE_MS_P = OFFLINE_MS,
   parameter int unsigned HOUR_MS_P    = HOUR_MS,
   parameter int unsigned MS_CYC_P     = MS_CYC,
   parameter int unsigned HOLD_MIN_P   = HOLD_MIN_CYC,
   parameter int unsigned HOLD_MAX_P   = HOLD_MAX_CYC
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   input  wire logic [N_PINS-1:0] multi_pin_in,
   input  wire logic [2:0]        button_in,
   output var  logic              outputs_on,
   output var  logic              interlock_indicator,
   output var  logic              restart_symbol,
   output var  logic              offline,
   output var  logic              waiting_config,
   output var  logic              display_rotate,
   output var  logic              irq
);

   localparam int unsigned PIN_W = N_PINS + 3;

   typedef struct packed {
      logic [PIN_W-1:0] s1;        // First sync stage, read only by s2
      logic [PIN_W-1:0] s2;
      logic             sw_deb;    // Debounced switch level
      logic [4:0]       deb_cnt;
      logic [2:0]       btn_prev;
      logic [31:0]      hold_cnt;
      logic             hold_over;
      logic [16:0]      ms_cnt;    // Millisecond prescaler, fits 100000
      logic [31:0]      off_ms;
      logic [31:0]      hour_ms;
      logic [31:0]      hours;
      ric_state_t       state;
      logic             stop;
      logic             fault;
      logic             obj;
      logic             rotate;
      logic [3:0]       sel;
      logic [31:0]      ip;
      logic [1:0]       remotes;
      logic             menu_open;
      ric_menu_t        menu;
      logic [EV_W-1:0]  ev;
      logic [EV_W-1:0]  mask;
      logic [31:0]      rdata;
      logic             ready;
      logic             slverr;
      logic             o_on;
      logic             o_led;
      logic             o_off;
      logic             o_wait;
      logic             o_irq;
   } ric_regs_t;

   ric_regs_t q, d;

   logic             sw_raw;
   logic             sw_close;
   logic             sw_open;
   logic             req_ok;
   logic             restart;
   logic [EV_W-1:0]  ev_set;
   logic             wr;
   logic             rd;
   logic             ms_tick;
   logic [2:0]       btn_rise;

   // Next-state logic for the whole block
   always_comb begin
      d = q;
      ev_set = '0;
      // Pins pass two flops before any logic looks at them
      d.s1 = {button_in, multi_pin_in};
      d.s2 = q.s1;
      sw_raw = q.s2[q.sel[$clog2(N_PINS)-1:0]];
      btn_rise = q.s2[PIN_W-1 -: 3] & ~q.btn_prev;
      d.btn_prev = q.s2[PIN_W-1 -: 3];

      // Debounce: level must differ for a run of cycles before it counts
      if (sw_raw != q.sw_deb) begin
         d.deb_cnt = q.deb_cnt + 5'd1;
         if (q.deb_cnt == 5'(DEBOUNCE_CYC - 1)) begin
            d.sw_deb = sw_raw;
            d.deb_cnt = '0;
         end
      end else begin
         d.deb_cnt = '0;
      end
      sw_close = d.sw_deb & ~q.sw_deb;
      sw_open  = ~d.sw_deb & q.sw_deb;

      // Hold timer; stops one count past the maximum so it never wraps
      if (sw_close) begin
         d.hold_cnt = '0;
         d.hold_over = 1'b0;
      end else if (q.sw_deb && !q.hold_over) begin
         d.hold_cnt = q.hold_cnt + 32'd1;
         if (q.hold_cnt >= HOLD_MAX_P) begin
            d.hold_over = 1'b1;
         end
      end
      req_ok = sw_open && !q.hold_over &&
               (q.hold_cnt >= HOLD_MIN_P);
      if (sw_open && q.hold_over) begin
         ev_set[EV_DISCARD] = 1'b1;
      end
      if (req_ok) begin
         ev_set[EV_ACCEPT] = 1'b1;
      end

      // Millisecond tick drives the offline and hour timers
      ms_tick = (q.ms_cnt == 17'(MS_CYC_P - 1));
      d.ms_cnt = ms_tick ? '0 : q.ms_cnt + 17'd1;

      // APB decode: one wait state, write/read in the first access cycle
      wr = psel && penable && pwrite && !q.ready;
      rd = psel && penable && !pwrite && !q.ready;
      d.ready = psel && penable && !q.ready;
      d.slverr = 1'b0;
      restart = 1'b0;
      if (wr) begin
         case (paddr)
            REG_CTRL: begin
               d.stop   = pwdata[CTRL_STOP];
               d.fault  = pwdata[CTRL_FAULT];
               d.obj    = pwdata[CTRL_OBJ];
               d.rotate = pwdata[CTRL_ROTATE];
               d.sel    = pwdata[CTRL_SEL_LO +: 4];
               if (pwdata[CTRL_FACTORY]) begin
                  d.ip = IP_DEFAULT;
                  d.remotes = CHAIN_DEF;
                  d.rotate = 1'b0;
                  d.sel = '0;
                  d.state = RIC_ST_WAITCFG;
                  d.off_ms = '0;
                  ev_set[EV_FACTORY] = 1'b1;
               end
            end
            REG_IRQ_STAT: d.ev = q.ev & ~pwdata[EV_W-1:0];
            REG_IRQ_MASK: d.mask = pwdata[EV_W-1:0];
            REG_IP_ADDR:  d.ip = pwdata;
            REG_CHAIN:    d.remotes = pwdata[1:0];
            REG_STATUS, REG_HOURS, REG_MENU: ;
            default:      d.slverr = 1'b1;
         endcase
      end
      d.rdata = '0;
      if (rd) begin
         case (paddr)
            REG_CTRL: d.rdata = {20'h0_0000, q.sel, 3'h0, q.rotate,
                                 1'b0, q.obj, q.fault, q.stop};
            REG_STATUS: d.rdata = {24'h00_0000, 3'h0, q.o_wait,
                                   q.o_off, q.o_led, q.o_on,
                                   q.hold_over};
            REG_IRQ_STAT: d.rdata = {27'h000_0000, q.ev};
            REG_IRQ_MASK: d.rdata = {27'h000_0000, q.mask};
            REG_IP_ADDR:  d.rdata = q.ip;
            // Last reserved address: base + 1 + two per remote
            REG_CHAIN: d.rdata = q.ip + 32'd1 +
                                 {29'h0000_0000, q.remotes, 1'b0};
            REG_HOURS: d.rdata = q.hours;
            REG_MENU:  d.rdata = {29'h0000_0000, q.menu, q.menu_open};
            default:   d.slverr = 1'b1;
         endcase
      end

      // Local menu; square on the settings entry restarts the unit
      if (btn_rise[BTN_SQUARE]) begin
         if (!q.menu_open) begin
            d.menu_open = 1'b1;
            d.menu = RIC_MENU_INFO;
         end else if (q.menu == RIC_MENU_EXIT) begin
            d.menu_open = 1'b0;
         end else if (q.menu == RIC_MENU_SET) begin
            restart = 1'b1;
            d.menu_open = 1'b0;
         end
      end else if (q.menu_open && btn_rise[BTN_DOWN]) begin
         case (q.menu)
            RIC_MENU_INFO: d.menu = RIC_MENU_SET;
            RIC_MENU_SET:  d.menu = RIC_MENU_EXIT;
            default:       d.menu = RIC_MENU_INFO;
         endcase
      end else if (q.menu_open && btn_rise[BTN_UP]) begin
         case (q.menu)
            RIC_MENU_EXIT: d.menu = RIC_MENU_SET;
            RIC_MENU_SET:  d.menu = RIC_MENU_INFO;
            default:       d.menu = RIC_MENU_EXIT;
         endcase
      end

      // Run state machine
      case (q.state)
         RIC_ST_STARTUP: begin
            if (ms_tick) begin
               d.off_ms = q.off_ms + 32'd1;
            end
            if (q.off_ms >= OFFLINE_MS_P) begin
               d.state = RIC_ST_INTERLOCK;
               ev_set[EV_READY] = 1'b1;
            end
         end
         RIC_ST_INTERLOCK: begin
            if (q.fault) begin
               d.state = RIC_ST_LOCKOUT;
            end else if (req_ok && !q.obj && !q.stop) begin
               d.state = RIC_ST_RUN;
            end
         end
         RIC_ST_RUN: begin
            if (q.fault) begin
               d.state = RIC_ST_LOCKOUT;
            end else if (q.stop || q.obj) begin
               d.state = RIC_ST_INTERLOCK;
            end
         end
         RIC_ST_LOCKOUT: begin
            if (req_ok && !q.fault) begin
               d.state = RIC_ST_STARTUP;
               d.off_ms = '0;
            end
         end
         RIC_ST_WAITCFG: ;
         default: d.state = RIC_ST_STARTUP;
      endcase
      if (q.state != RIC_ST_LOCKOUT && d.state == RIC_ST_LOCKOUT) begin
         ev_set[EV_LOCKOUT] = 1'b1;
      end
      // Menu reset and a config write after factory restore both rerun tests
      if (restart || (wr && paddr == REG_CTRL && q.state == RIC_ST_WAITCFG
                      && !pwdata[CTRL_FACTORY])) begin
         d.state = RIC_ST_STARTUP;
         d.off_ms = '0;
      end

      // Run-time hours accumulate whenever powered
      if (ms_tick) begin
         if (q.hour_ms == 32'(HOUR_MS_P - 1)) begin
            d.hour_ms = '0;
            d.hours = q.hours + 32'd1;
         end else begin
            d.hour_ms = q.hour_ms + 32'd1;
         end
      end

      // Sticky events: a new event wins over a same-cycle clear
      d.ev = d.ev | ev_set;

      // Registered outputs
      d.o_on   = (d.state == RIC_ST_RUN);
      d.o_led  = (d.state == RIC_ST_INTERLOCK) && !q.obj;
      d.o_off  = (d.state == RIC_ST_STARTUP);
      d.o_wait = (d.state == RIC_ST_WAITCFG);
      d.o_irq  = |(d.ev & d.mask);
   end

   // Single state register; async reset loads constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{state: RIC_ST_STARTUP, ip: IP_DEFAULT,
                remotes: CHAIN_DEF, menu: RIC_MENU_INFO,
                o_off: 1'b1, default: '0};
      end else begin
         q <= d;
      end
   end

   assign prdata              = q.rdata;
   assign pready              = q.ready;
   assign pslverr             = q.slverr;
   assign outputs_on          = q.o_on;
   assign interlock_indicator = q.o_led;
   assign restart_symbol      = q.o_led;
   assign offline             = q.o_off;
   assign waiting_config      = q.o_wait;
   assign display_rotate      = q.rotate;
   assign irq                 = q.o_irq;

endmodule // ric_top

`default_nettype wire

// file: bench/ric_checker.sv
// Concurrent checks on the restart interlock control block ports.
// Assumes a single pclk domain; bound into every ric_top instance below.
`timescale 1ns/1ps
`default_nettype none

module ric_checker
   import ric_pkg::*;
#(
   parameter int unsigned N_PINS = 4
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [N_PINS-1:0] multi_pin_in,
   input wire logic [2:0]        button_in,
   input wire logic              outputs_on,
   input wire logic              interlock_indicator,
   input wire logic              restart_symbol,
   input wire logic              offline,
   input wire logic              waiting_config,
   input wire logic              display_rotate,
   input wire logic              irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // First access edge of a transfer, answer still pending
   sequence s_access;
      psel && penable && !pready;
   endsequence
   // Answer is a single-cycle pulse one edge later
   sequence s_answer;
      pready ##1 !pready;
   endsequence

   property p_answer;
      s_access |=> s_answer;
   endproperty
   a_answer: assert property (p_answer) else $error("apb answer late");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("pslverr without pready");
   property p_rdata;
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_rdata: assert property (p_rdata) else $error("prdata not idle zero");
   property p_symbol;
      restart_symbol == interlock_indicator;
   endproperty
   a_symbol: assert property (p_symbol) else $error("symbol mismatch");
   property p_run_excl;
      outputs_on |-> !interlock_indicator;
   endproperty
   a_run_excl: assert property (p_run_excl) else $error("run and interlock");
   property p_offline;
      offline |-> !outputs_on && !interlock_indicator;
   endproperty
   a_offline: assert property (p_offline) else $error("on while offline");
   property p_wait_off;
      waiting_config |-> !outputs_on && !offline;
   endproperty
   a_wait_off: assert property (p_wait_off) else $error("on while waiting");
   // Outputs may only come on out of the amber interlock state
   property p_restart;
      $rose(outputs_on) |->
         $past(interlock_indicator) || $past(interlock_indicator, 2);
   endproperty
   a_restart: assert property (p_restart) else $error("run w/o interlock");
endmodule // ric_checker

bind ric_top ric_checker #(.N_PINS(N_PINS)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .multi_pin_in(multi_pin_in), .button_in(button_in),
   .outputs_on(outputs_on), .interlock_indicator(interlock_indicator),
   .restart_symbol(restart_symbol), .offline(offline),
   .waiting_config(waiting_config), .display_rotate(display_rotate),
   .irq(irq));

`default_nettype wire

// file: bench/ric_switch_model.sv
// Operator reset switch: a normally open contact to the 24 V supply.
// Assumes the bench pulses press for one pclk cycle with a hold length.
`timescale 1ns/1ps
`default_nettype none

module ric_switch_model (
   input  wire logic        pclk,
   input  wire logic        press,
   input  wire logic [31:0] hold_cyc,
   output var  logic        contact
);
   logic [31:0] cnt_q = 32'h0000_0000;

   // Count the hold down; the contact opens again when it expires
   always @(posedge pclk) begin
      if (press) cnt_q <= hold_cyc;
      else if (cnt_q != 32'h0000_0000) cnt_q <= cnt_q - 32'h0000_0001;
   end
   // Closed contact reads high, open contact reads low, never floating
   assign contact = (cnt_q != 32'h0000_0000);
endmodule // ric_switch_model

`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for ric_top with a shortened startup timer.
// Assumes ric_pkg and the switch model; hold limits are shortened too.
`timescale 1ns/1ps
`default_nettype none

module tb;
   import ric_pkg::*;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } ric_row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        press = 1'b0;
   logic [31:0] hold = 32'h0000_0000;
   logic        contact;
   logic [2:0]  button_in = 3'h0;
   logic        outputs_on, indicator, symbol, offline, waitcfg, rotate, irq;
   logic        err;
   logic [31:0] r;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;
   ric_row_t    rows [10] = '{
      '{1'b0, REG_STATUS,   32'h0, 32'h0000_0005, 1'b0},
      '{1'b0, REG_IP_ADDR,  32'h0, 32'hC0A8_000A, 1'b0},
      '{1'b1, REG_CHAIN,    32'h0, 32'h0, 1'b0},
      '{1'b0, REG_CHAIN,    32'h0, 32'hC0A8_000B, 1'b0},
      '{1'b1, REG_CHAIN,    32'h3, 32'h0, 1'b0},
      '{1'b0, REG_CHAIN,    32'h0, 32'hC0A8_0011, 1'b0},
      '{1'b1, REG_IP_ADDR,  32'h0A00_0001, 32'h0, 1'b0},
      '{1'b1, REG_CHAIN,    32'h2, 32'h0, 1'b0},
      '{1'b0, REG_CHAIN,    32'h0, 32'h0A00_0006, 1'b0},
      '{1'b0, 8'h20,        32'h0, 32'h0, 1'b1}};
   logic [2:0]  mbtn [7] = '{3'd0, 3'd2, 3'd2, 3'd2, 3'd1, 3'd1, 3'd0};
   logic [31:0] mexp [6] = '{32'h1, 32'h3, 32'h7, 32'h1, 32'h7, 32'h3};

   ric_top #(.OFFLINE_MS_P(3), .HOUR_MS_P(5), .MS_CYC_P(10),
             .HOLD_MIN_P(300), .HOLD_MAX_P(600)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .multi_pin_in({3'b000, contact}), .button_in(button_in),
      .outputs_on(outputs_on), .interlock_indicator(indicator),
      .restart_symbol(symbol), .offline(offline), .waiting_config(waitcfg),
      .display_rotate(rotate), .irq(irq));
   ric_switch_model u_sw (.pclk(pclk), .press(press), .hold_cyc(hold),
                          .contact(contact));

   // 100 MHz clock and a cycle ceiling well above the planned run
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic results;
      $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Setup, then access held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   // Startup timer is 30 cycles here; 500 gives ample margin
   task automatic wait_up;
      for (int i = 0; i < 500 && offline !== 1'b0; i++) @(posedge pclk);
   endtask
   task automatic btn(input logic [2:0] b);
      button_in <= 3'b001 << b;
      tick(40);
      button_in <= 3'b000;
      tick(40);
   endtask
   // Close the contact for len cycles, then allow debounce to settle
   task automatic push(input int len);
      press <= 1'b1;
      hold  <= len;
      tick(1);
      press <= 1'b0;
      tick(len + 50);
   endtask

   // Main sequence
   initial begin
      tick(12);
      chk({31'h0, offline}, 32'h1);
      chk({31'h0, outputs_on}, 32'h0);
      presetn <= 1'b1;
      wait_up();
      tick(3);
      rd(REG_IRQ_STAT, 32'h0000_0004);
      apb(1'b1, REG_IRQ_MASK, 32'h0000_0004);
      tick(2);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, REG_IRQ_STAT, 32'h0000_0004);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, symbol}, 32'h1);
      $display("test startup done");
      apb(1'b1, REG_CTRL, 32'h0000_0004);
      tick(3);
      chk({31'h0, indicator}, 32'h0);
      apb(1'b1, REG_CTRL, 32'h0000_0010);
      tick(3);
      chk({31'h0, indicator}, 32'h1);
      chk({31'h0, rotate}, 32'h1);
      $display("test object done");
      push(200);
      rd(REG_IRQ_STAT, 32'h0);
      chk({31'h0, outputs_on}, 32'h0);
      $display("test short_press done");
      push(450);
      chk({31'h0, outputs_on}, 32'h1);
      rd(REG_IRQ_STAT, 32'h0000_0001);
      apb(1'b1, REG_CTRL, 32'h0000_0011);
      tick(3);
      chk({31'h0, outputs_on}, 32'h0);
      push(450);
      chk({31'h0, outputs_on}, 32'h0);
      apb(1'b1, REG_CTRL, 32'h0000_0014);
      push(450);
      chk({31'h0, outputs_on}, 32'h0);
      apb(1'b1, REG_CTRL, 32'h0000_0010);
      push(800);
      chk({31'h0, outputs_on}, 32'h0);
      rd(REG_IRQ_STAT, 32'h0000_0003);
      apb(1'b1, REG_IRQ_STAT, 32'h0000_0003);
      $display("test restart done");
      for (int i = 0; i < 10; i++) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(r, rows[i].x);
         chk({31'h0, err}, {31'h0, rows[i].e});
      end
      $display("test table done");
      apb(1'b1, REG_CTRL, 32'h0000_0008);
      tick(5);
      chk({31'h0, waitcfg}, 32'h1);
      rd(REG_IP_ADDR, 32'hC0A8_000A);
      rd(REG_IRQ_STAT, 32'h0000_0010);
      apb(1'b1, REG_CTRL, 32'h0);
      tick(2);
      chk({31'h0, offline}, 32'h1);
      wait_up();
      $display("test factory done");
      for (int i = 0; i < 6; i++) begin
         btn(mbtn[i]);
         rd(REG_MENU, mexp[i]);
      end
      button_in <= 3'b001 << mbtn[6];
      tick(6);
      chk({31'h0, offline}, 32'h1);
      button_in <= 3'b000;
      wait_up();
      $display("test menu done");
      apb(1'b1, REG_IRQ_STAT, 32'h0000_001F);
      apb(1'b1, REG_CTRL, 32'h0000_0002);
      tick(5);
      rd(REG_IRQ_STAT, 32'h0000_0008);
      apb(1'b1, REG_CTRL, 32'h0);
      tick(5);
      chk({31'h0, indicator}, 32'h0);
      chk({31'h0, outputs_on}, 32'h0);
      push(450);
      rd(REG_IRQ_STAT, 32'h0000_000D);
      chk({31'h0, indicator}, 32'h1);
      $display("test lockout done");
      presetn <= 1'b0;
      tick(3);
      chk({31'h0, offline}, 32'h1);
      presetn <= 1'b1;
      tick(2);
      chk({31'h0, offline}, 32'h1);
      $display("test second_reset done");
      results();
   end
endmodule // tb

`default_nettype wire
